//--- common/lic_pkg.sv
// Purpose: constants shared by the LED indicator configuration block
// Assumes: 10 MHz core clock, 32-bit Avalon-MM register access
// Notes:   register offsets are word indexes; byte address is four times the index

// ************************************************
// package
// ************************************************
package lic_pkg;

  localparam int NUM_LED = 4;

  // register word indexes
  localparam logic [5:0] IDX_LED_ZERO_CONFIG  = 6'h24;
  localparam logic [5:0] IDX_LED_ONE_CONFIG   = 6'h25;
  localparam logic [5:0] IDX_LED_TWO_CONFIG   = 6'h26;
  localparam logic [5:0] IDX_LED_THREE_CONFIG = 6'h27;

  // field positions
  localparam int BIT_LED_OUTPUT_GATE     = 1;
  localparam int BIT_LED_INVERT          = 2;
  localparam int BIT_LED_STRETCH         = 3;
  localparam int BIT_TEN_MEG_SELECT      = 4;
  localparam int BIT_HUNDRED_MEG_SELECT  = 5;
  localparam int BIT_COND_LO             = 12;
  localparam int BIT_COND_HI             = 16;
  localparam int NUM_COND                = 5;
  localparam int BIT_LED_DRIVE_MIRROR    = 31;

  // reset value and writable bits (bits 0, 7, 30:17 reserved, 31 read-only)
  localparam logic [31:0] CFG_RESET = 32'h0000_040e;
  localparam logic [31:0] CFG_WMASK = 32'h0001_ff7e;

  // timing
  localparam int CLK_KHZ          = 10_000;
  localparam int BLINK_SLOW_MS    = 500;   // half period of 1 Hz
  localparam int BLINK_FAST_MS    = 125;   // half period of 4 Hz
  localparam int STRETCH_MS       = 50;
  localparam int BLINK_SLOW_CYC   = BLINK_SLOW_MS * CLK_KHZ;
  localparam int BLINK_FAST_CYC   = BLINK_FAST_MS * CLK_KHZ;
  localparam int STRETCH_CYC      = STRETCH_MS * CLK_KHZ;

  // bus handshake phases
  typedef enum logic [1:0] {
    LIC_BUS_IDLE = 2'b00,
    LIC_BUS_ACK  = 2'b01
  } lic_bus_e;

endpackage : lic_pkg

//--- design/lic_led_chan.sv
// Purpose: one LED channel: condition combine, inversion, stretch, gate
// Assumes: condition inputs are on the core clock
// Notes:   led_q is registered and also feeds the read-back mirror

`timescale 1ns/1ps
`default_nettype none

module lic_led_chan #(
  parameter int STRETCH_CYC = lic_pkg::STRETCH_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // configuration and conditions
  input  wire logic [31:0] cfg,
  input  wire logic [4:0]  cond,
  input  wire logic [1:0]  spd_latch,
  input  wire logic        blink_slow,
  input  wire logic        blink_fast,
  // led drive
  output logic             led_q
);

  logic        raw;
  logic        pol;
  logic        held_q;
  logic [31:0] cnt_q;

  // ************************************************
  // combine and invert
  // ************************************************
  always_comb begin
    raw = |(cfg[lic_pkg::BIT_COND_HI:lic_pkg::BIT_COND_LO] & cond);
    raw = raw | (cfg[lic_pkg::BIT_TEN_MEG_SELECT] & spd_latch[0] & blink_slow);
    raw = raw | (cfg[lic_pkg::BIT_HUNDRED_MEG_SELECT] & spd_latch[1] & blink_fast);
    pol = raw ^ cfg[lic_pkg::BIT_LED_INVERT];
  end

  // ************************************************
  // pulse stretch
  // ************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      held_q <= 1'b0;
      cnt_q  <= 32'h0000_0000;
    end else if (ce) begin
      if (!cfg[lic_pkg::BIT_LED_STRETCH]) begin
        held_q <= pol;
        cnt_q  <= 32'h0000_0000;
      end else if (cnt_q != 32'h0000_0000) begin
        cnt_q <= cnt_q - 32'h0000_0001;
      end else if (pol != held_q) begin
        held_q <= pol;
        cnt_q  <= 32'(STRETCH_CYC - 1);
      end
    end
  end

  // ************************************************
  // enable gate
  // ************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      led_q <= 1'b0;
    end else if (ce) begin
      led_q <= held_q & cfg[lic_pkg::BIT_LED_OUTPUT_GATE];
    end
  end

endmodule : lic_led_chan

`default_nettype wire

//--- design/lic_top.sv
// Purpose: four LED configuration registers on Avalon-MM driving four LEDs
// Assumes: status conditions and speed latches come from core-clock logic
// Notes:   one wait state on every access; unmapped reads return zero

`timescale 1ns/1ps
`default_nettype none

module lic_top #(
  parameter int BLINK_SLOW_CYC = lic_pkg::BLINK_SLOW_CYC,
  parameter int BLINK_FAST_CYC = lic_pkg::BLINK_FAST_CYC,
  parameter int STRETCH_CYC    = lic_pkg::STRETCH_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // status conditions
  input  wire logic        tx_active,
  input  wire logic        rx_active,
  input  wire logic        babble_station_select,
  input  wire logic        simultaneous_txrx_flag,
  input  wire logic        line_sense_select,
  input  wire logic        ten_meg_latch,
  input  wire logic        hundred_meg_latch,
  // leds
  output logic [3:0]       led_out
);

  lic_pkg::lic_bus_e  bus_q;
  logic [31:0]        cfg_q [lic_pkg::NUM_LED];
  logic [31:0]        blink_slow_cnt_q;
  logic [31:0]        blink_fast_cnt_q;
  logic               blink_slow_q;
  logic               blink_fast_q;
  logic [4:0]         cond;
  logic [31:0]        wmask;
  logic               req;
  logic [2:0]         rd_sel;

  // ************************************************
  // decode
  // ************************************************
  function automatic logic [2:0] led_sel(input logic [7:0] addr);
    logic [2:0] r;
    r = 3'h4;
    case (addr[7:2])
      lic_pkg::IDX_LED_ZERO_CONFIG:  r = 3'h0;
      lic_pkg::IDX_LED_ONE_CONFIG:   r = 3'h1;
      lic_pkg::IDX_LED_TWO_CONFIG:   r = 3'h2;
      lic_pkg::IDX_LED_THREE_CONFIG: r = 3'h3;
      default:                       r = 3'h4;
    endcase
    return r;
  endfunction : led_sel

  assign cond  = {line_sense_select, simultaneous_txrx_flag, babble_station_select, rx_active, tx_active};
  assign req   = avs_read | avs_write;
  assign rd_sel = led_sel(avs_address);
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} & lic_pkg::CFG_WMASK;

  // ************************************************
  // bus handshake
  // ************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_q           <= lic_pkg::LIC_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      case (bus_q)
        lic_pkg::LIC_BUS_IDLE: begin
          if (req) begin
            bus_q           <= lic_pkg::LIC_BUS_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        lic_pkg::LIC_BUS_ACK: begin
          bus_q           <= lic_pkg::LIC_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_q           <= lic_pkg::LIC_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ************************************************
  // read data
  // ************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce) begin
      if (bus_q == lic_pkg::LIC_BUS_IDLE && avs_read) begin
        if (rd_sel < 3'h4) begin
          avs_readdata <= (cfg_q[rd_sel[1:0]] & lic_pkg::CFG_WMASK)
                          | ({31'h0000_0000, led_out[rd_sel[1:0]]}
                             << lic_pkg::BIT_LED_DRIVE_MIRROR);
        end else begin
          avs_readdata <= 32'h0000_0000;
        end
      end
    end
  end

  // ************************************************
  // configuration registers and channels
  // ************************************************
  genvar g;
  generate
    for (g = 0; g < lic_pkg::NUM_LED; g++) begin : g_led
      always_ff @(posedge clk) begin
        if (!resetn) begin
          cfg_q[g] <= lic_pkg::CFG_RESET;
        end else if (ce) begin
          if (bus_q == lic_pkg::LIC_BUS_ACK && avs_write && led_sel(avs_address) == 3'(g)) begin
            cfg_q[g] <= (cfg_q[g] & ~wmask) | (avs_writedata & wmask);
          end
        end
      end

      lic_led_chan #(
        .STRETCH_CYC (STRETCH_CYC)
      ) u_chan (
        .clk        (clk),
        .resetn     (resetn),
        .ce         (ce),
        .cfg        (cfg_q[g]),
        .cond       (cond),
        .spd_latch  ({hundred_meg_latch, ten_meg_latch}),
        .blink_slow (blink_slow_q),
        .blink_fast (blink_fast_q),
        .led_q      (led_out[g])
      );
    end
  endgenerate

  // ************************************************
  // blink generators
  // ************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      blink_slow_cnt_q <= 32'h0000_0000;
      blink_slow_q     <= 1'b0;
    end else if (ce) begin
      if (blink_slow_cnt_q == 32'(BLINK_SLOW_CYC - 1)) begin
        blink_slow_cnt_q <= 32'h0000_0000;
        blink_slow_q     <= ~blink_slow_q;
      end else begin
        blink_slow_cnt_q <= blink_slow_cnt_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      blink_fast_cnt_q <= 32'h0000_0000;
      blink_fast_q     <= 1'b0;
    end else if (ce) begin
      if (blink_fast_cnt_q == 32'(BLINK_FAST_CYC - 1)) begin
        blink_fast_cnt_q <= 32'h0000_0000;
        blink_fast_q     <= ~blink_fast_q;
      end else begin
        blink_fast_cnt_q <= blink_fast_cnt_q + 32'h0000_0001;
      end
    end
  end

endmodule : lic_top

`default_nettype wire

//--- verification/lic_led_model.sv
// Purpose: indicator lamps on the led outputs
// Assumes: lamp lights while its drive is high
// Notes:   counts level changes of lamp zero for blink rate checks
`timescale 1ns/1ps
`default_nettype none
// ****
// lamp model
// ****
module lic_led_model (
  input wire logic       clk,
  input wire logic [3:0] led,
  output logic [7:0]     toggles0
);
  logic       prev = 1'b0;
  logic [7:0] cnt_q = 8'h00;
  assign toggles0 = cnt_q;
  always @(posedge clk) begin
    if (led[0] !== prev) cnt_q <= cnt_q + 8'h01;
    prev <= led[0];
  end
endmodule : lic_led_model
`default_nettype wire

//--- verification/lic_top_bench.sv
// Purpose: self-checking bench for lic_top
// Assumes: short blink and stretch counts
// Notes:   bus signals change only right after rising edges
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module lic_top_bench;
  logic clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, tl = 1'b0, hl = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  be = 4'hf;
  logic [7:0]  avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic        avs_waitrequest;
  logic [4:0]  cv = 5'h00;
  logic [3:0]  led_out;
  logic [7:0]  tog;
  int err_count = 0, check_count = 0;
  always #50 clk = ~clk;
  lic_top #(.BLINK_SLOW_CYC(8), .BLINK_FAST_CYC(4), .STRETCH_CYC(3)) uut (.clk, .resetn, .ce(ce),
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(be), .avs_readdata,
    .avs_waitrequest, .tx_active(cv[0]), .rx_active(cv[1]), .babble_station_select(cv[2]),
    .simultaneous_txrx_flag(cv[3]), .line_sense_select(cv[4]), .ten_meg_latch(tl),
    .hundred_meg_latch(hl), .led_out);
  lic_led_model u_led (.clk, .led(led_out), .toggles0(tog));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h", $time, m, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    chk(32'(n), 32'h2, "answer latency");
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e, m);
  endtask : rd
  task automatic t_dflt;
    cyc(6);
    for (int i = 0; i < 4; i++) rd(8'h90 + 8'(4 * i), 32'h8000_040e, "default");
    chk({28'h0, led_out}, 32'hf, "default led");
    $display("test default done");
  endtask : t_dflt
  task automatic t_cond;
    for (int n = 0; n < 4; n++)
      for (int b = 0; b < 5; b++) begin
        wr(8'h90 + 8'(4 * n), 32'h2 | (32'h1000 << b));
        cv <= 5'h1 << b;
        cyc(3);
        chk({31'h0, led_out[n]}, 32'h1, "cond on");
        cv <= 5'h0;
        cyc(3);
        rd(8'h90 + 8'(4 * n), 32'h2 | (32'h1000 << b), "cond off");
        wr(8'h90 + 8'(4 * n), 32'h0);
      end
    $display("test conditions done");
  endtask : t_cond
  task automatic t_gate;
    int n;
    wr(8'h90, 32'h1000);
    cv <= 5'h1;
    cyc(3);
    chk({31'h0, led_out[0]}, 32'h0, "gated");
    rd(8'h90, 32'h1000, "gate keeps fields");
    wr(8'h90, 32'h1006);
    cyc(3);
    chk({31'h0, led_out[0]}, 32'h0, "inverted");
    cv <= 5'h0;
    wr(8'h90, 32'h100a);
    cyc(6);
    cv <= 5'h1;
    @(posedge clk);
    cv <= 5'h0;
    n = 0;
    repeat (12) begin
      @(posedge clk);
      if (led_out[0] === 1'b1) n++;
    end
    chk(32'(n >= 3 && n <= 4), 32'h1, "stretch");
    $display("test gate done");
  endtask : t_gate
  task automatic t_blink;
    logic [7:0] t, d;
    wr(8'h90, 32'h12);
    tl <= 1'b1;
    cyc(4);
    t = tog;
    cyc(80);
    d = tog - t;
    chk(32'(d >= 8'h09 && d <= 8'h0b), 32'h1, "slow blink");
    wr(8'h90, 32'h22);
    tl <= 1'b0;
    hl <= 1'b1;
    cyc(4);
    t = tog;
    cyc(80);
    d = tog - t;
    chk(32'(d >= 8'h13 && d <= 8'h15), 32'h1, "fast blink");
    hl <= 1'b0;
    $display("test blink done");
  endtask : t_blink
  task automatic t_map;
    wr(8'h90, 32'hffff_ffff);
    cyc(8);
    rd(8'h90, 32'h8001_ff7e, "write mask");
    wr(8'h80, 32'hffff_ffff);
    rd(8'h80, 32'h0, "unmapped");
    rd(8'h94, 32'h0, "own register");
    $display("test map done");
  endtask : t_map
  task automatic t_hold;
    wr(8'h9c, 32'h1002);
    ce <= 1'b0;
    cv <= 5'h1;
    cyc(4);
    chk({31'h0, led_out[3]}, 32'h0, "frozen");
    ce <= 1'b1;
    cyc(3);
    chk({31'h0, led_out[3]}, 32'h1, "resumed");
    cv <= 5'h0;
    be <= 4'h1;
    wr(8'h98, 32'hffff_ffff);
    be <= 4'hf;
    cyc(4);
    rd(8'h98, 32'h8000_007e, "lane mask");
    resetn <= 1'b0;
    cyc(2);
    resetn <= 1'b1;
    cyc(4);
    rd(8'h90, 32'h8000_040e, "reset again");
    rd(8'h9c, 32'h8000_040e, "reset again");
    $display("test hold done");
  endtask : t_hold
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_dflt();
    t_cond();
    t_gate();
    t_blink();
    t_map();
    t_hold();
    final_report();
  end
endmodule : lic_top_bench
`default_nettype wire

//--- verification/lic_top_chk.sv
// Purpose: bus and led port checks for lic_top
// Assumes: one clock, resetn synchronous active low
// Notes:   bound to lic_top at the foot of this file
`timescale 1ns/1ps
`default_nettype none
// ****
// checker
// ****
module lic_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        ce,
  // avalon-mm slave
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [7:0]  avs_address,
  input wire logic [31:0] avs_readdata,
  // leds
  input wire logic [3:0]  led_out
);
  logic [3:0] led_d;
  always_ff @(posedge clk) led_d <= led_out;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest && ce; endsequence
  sequence s_rdack; avs_read && !avs_waitrequest; endsequence
  property p_ack; s_req |=> !avs_waitrequest; endproperty
  property p_one; !avs_waitrequest && ce |=> avs_waitrequest; endproperty
  property p_idle; !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest; endproperty
  property p_rsv; s_rdack |-> (avs_readdata & 32'h7ffe0081) == 32'h0; endproperty
  property p_unmap; (s_rdack and (avs_address[7:4] != 4'h9)) |-> avs_readdata == 32'h0; endproperty
  property p_mir; (s_rdack and (avs_address[7:4] == 4'h9))
    |-> avs_readdata[31] == led_d[avs_address[3:2]]; endproperty
  property p_hold; !avs_read |-> $stable(avs_readdata); endproperty
  property p_rst; $rose(resetn) |-> avs_waitrequest && led_out == 4'h0 && avs_readdata == 32'h0; endproperty
  a_ack: assert property (p_ack) else $error("no answer one cycle after request");
  a_one: assert property (p_one) else $error("waitrequest low too long");
  a_idle: assert property (p_idle) else $error("answer without request");
  a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  a_mir: assert property (p_mir) else $error("mirror bit differs from led");
  a_hold: assert property (p_hold) else $error("readdata moved without read");
  a_rst: assert property (p_rst) else $error("outputs not at reset values");
endmodule : lic_chk
bind lic_top lic_chk u_chk (.clk, .resetn, .ce, .avs_read, .avs_write, .avs_waitrequest,
  .avs_address, .avs_readdata, .led_out);
`default_nettype wire
